// [hdl/dbc_pkg.sv]
// Constants and types of the background debug command engine
// Function
// - memory-dump accepted only after sync, no-op, memory-read or dump; else illegal response, flag.
// - no-operation leaves the debug address pointer unchanged.
// - operand size is decoded anew for every memory-dump command.
// - with-status variants send status byte first, captured when the memory access is acknowledged (register read: when the command is taken).
// - with acknowledge enabled, an acknowledge pulse precedes returned data bytes.
// - memory-fill writes at the pointer, then advances it, CPU keeps running.
// - with-status fill does the same write and advance and returns status.
// - CPU register read always returns 32 bits.
// - unimplemented byte positions of a register read return zero.
// - register read selects the register by the command's register-number field.
// - register read outside background halt mode sets the flag, no access.
// - memory-read fetches from the command's address, CPU keeps running.
package dbc_pkg;
  localparam int DBC_AW = 24;
  localparam logic [3:0] DBC_OFS_CTRL = 4'h0;
  localparam logic [3:0] DBC_OFS_STAT = 4'h4;
  localparam logic [3:0] DBC_OFS_PTR  = 4'h8;
  localparam int DBC_CTRL_ACK_BIT  = 0;
  localparam int DBC_STAT_ACK_BIT  = 7;
  localparam int DBC_STAT_HALT_BIT = 6;
  localparam int DBC_STAT_ILL_BIT  = 5;
  localparam logic DBC_ACK_EN_RST = 1'b0;
  localparam logic [DBC_AW-1:0] DBC_PTR_RST = 24'h000000;
  localparam logic [7:0] DBC_ILL_RSP = 8'hEE;
  localparam logic [2:0] DBC_REG_BYTES = 3'h4;
  typedef enum logic [2:0]
  {
    DBC_CMD_SYNC  = 3'h0,
    DBC_CMD_NOP   = 3'h1,
    DBC_CMD_DUMP  = 3'h2,
    DBC_CMD_FILL  = 3'h3,
    DBC_CMD_RDMEM = 3'h4,
    DBC_CMD_RDREG = 3'h5
  } dbc_cmd_t;
  typedef enum logic [1:0]
  {
    DBC_SIZE_BYTE = 2'h0,
    DBC_SIZE_WORD = 2'h1,
    DBC_SIZE_LONG = 2'h2
  } dbc_size_t;
  typedef enum logic [2:0]
  {
    DBC_ST_IDLE   = 3'b000,
    DBC_ST_ACCESS = 3'b001,
    DBC_ST_ACK    = 3'b011,
    DBC_ST_STAT   = 3'b010,
    DBC_ST_DATA   = 3'b110
  } dbc_state_t;
endpackage

// [hdl/dbc_buf2.sv]
// Two-entry valid/ready buffer for returned bytes
`timescale 1ns/1ps
module dbc_buf2 #(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_reg [2];
  logic         wr_reg;
  logic         rd_reg;
  logic [1:0]   cnt_reg;
  logic         push;
  logic         pop;

  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wr_reg  <= 1'b0;
      rd_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wr_reg <= ~wr_reg;
      end
      if (pop)
      begin
        rd_reg <= ~rd_reg;
      end
      if (push & ~pop)
      begin
        cnt_reg <= cnt_reg + 2'h1;
      end
      else if (pop & ~push)
      begin
        cnt_reg <= cnt_reg - 2'h1;
      end
    end
  end
endmodule

// [hdl/dbc_engine.sv]
// Background debug command engine with Avalon-MM register slave
`timescale 1ns/1ps
module dbc_engine
  import dbc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              srst,
  // Avalon-MM slave
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // Decoded commands from the link
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire logic [2:0]        cmd_code,
  input  wire logic              with_status_variant,
  input  wire logic [1:0]        operand_size_field,
  input  wire logic [DBC_AW-1:0] cmd_addr,
  input  wire logic [31:0]       cmd_data,
  input  wire logic [3:0]        cpu_reg_number,
  // Returned bytes towards the link
  output logic                   rsp_valid,
  input  wire logic              rsp_ready,
  output logic [7:0]             rsp_data,
  output logic                   ack_pulse,
  // Device memory port
  output logic                   mem_req,
  output logic                   mem_we,
  output logic [DBC_AW-1:0]      mem_addr,
  output logic [1:0]             mem_size,
  output logic [31:0]            mem_wdata,
  input  wire logic              mem_ack,
  input  wire logic [31:0]       mem_rdata,
  // CPU register file
  input  wire logic              background_halt_mode,
  output logic [3:0]             cpu_reg_sel,
  input  wire logic [31:0]       cpu_reg_rdata,
  input  wire logic [3:0]        cpu_reg_impl
);
  dbc_state_t        state_reg;
  dbc_state_t        state_next;
  dbc_cmd_t          last_reg;
  dbc_cmd_t          cur_reg;
  logic              stat_en_reg;
  logic [1:0]        size_reg;
  logic [DBC_AW-1:0] ptr_reg;
  logic [DBC_AW-1:0] ptr_next;
  logic [31:0]       data_reg;
  logic [2:0]        nbytes_reg;
  logic [2:0]        sent_reg;
  logic              ack_en_reg;
  logic              illegal_cmd_flag;
  logic [7:0]        debug_status_low;
  logic [7:0]        stat_reg;
  logic              bus_ack_reg;
  logic              take;
  logic              legal;
  logic              ill_set;
  logic              ill_clr;
  logic              push;
  logic [7:0]        push_data;
  logic              push_ready;
  logic [2:0]        cmd_bytes;
  logic [DBC_AW-1:0] step;
  logic [DBC_AW-1:0] aligned;
  logic              returns_data;
  logic [31:0]       reg_masked;

  // Register slave: every access takes exactly one wait cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack_reg;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      bus_ack_reg <= 1'b0;
    end
    else
    begin
      bus_ack_reg <= (avs_read | avs_write) & ~bus_ack_reg;
    end
  end

  assign debug_status_low = {ack_en_reg, background_halt_mode, illegal_cmd_flag, 5'h00};

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      avs_readdata <= 32'h00000000;
    end
    else if (avs_read & ~bus_ack_reg)
    begin
      unique case (avs_address)
        DBC_OFS_CTRL: avs_readdata <= {31'h00000000, ack_en_reg};
        DBC_OFS_STAT: avs_readdata <= {24'h000000, debug_status_low};
        DBC_OFS_PTR:  avs_readdata <= {8'h00, ptr_reg};
        default:      avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // Writes land on the edge where the master sees waitrequest low
  wire bus_wr = avs_write & bus_ack_reg & avs_byteenable[0];

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ack_en_reg <= DBC_ACK_EN_RST;
    end
    else if (bus_wr && avs_address == DBC_OFS_CTRL)
    begin
      ack_en_reg <= avs_writedata[DBC_CTRL_ACK_BIT];
    end
  end

  // Flag is write-one-to-clear; a new illegal command wins over the clear
  assign ill_clr = bus_wr && avs_address == DBC_OFS_STAT && avs_writedata[DBC_STAT_ILL_BIT];

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      illegal_cmd_flag <= 1'b0;
    end
    else if (ill_set)
    begin
      illegal_cmd_flag <= 1'b1;
    end
    else if (ill_clr)
    begin
      illegal_cmd_flag <= 1'b0;
    end
  end

  // Command decode
  assign cmd_ready = (state_reg == DBC_ST_IDLE);
  assign take      = cmd_valid & cmd_ready;
  assign cmd_bytes = (operand_size_field == DBC_SIZE_BYTE) ? 3'h1 :
                     (operand_size_field == DBC_SIZE_WORD) ? 3'h2 : 3'h4;

  always_comb
  begin
    legal = 1'b1;
    if (cmd_code == DBC_CMD_DUMP)
    begin
      legal = (last_reg == DBC_CMD_SYNC) || (last_reg == DBC_CMD_NOP) ||
              (last_reg == DBC_CMD_RDMEM) || (last_reg == DBC_CMD_DUMP);
    end
    else if (cmd_code == DBC_CMD_RDREG)
    begin
      legal = background_halt_mode;
    end
  end

  assign ill_set = take & ~legal;

  // Pointer step of the current size, from the aligned address
  assign step    = {{(DBC_AW-3){1'b0}}, nbytes_reg};
  assign aligned = ptr_reg & ~(step - {{(DBC_AW-1){1'b0}}, 1'b1});

  always_comb
  begin
    ptr_next = ptr_reg;
    if (state_reg == DBC_ST_ACCESS && mem_ack &&
        (cur_reg == DBC_CMD_DUMP || cur_reg == DBC_CMD_FILL))
    begin
      ptr_next = aligned + step;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ptr_reg <= DBC_PTR_RST;
    end
    else if (take && cmd_code == DBC_CMD_RDMEM && legal)
    begin
      // Later dumps continue from the read address
      ptr_reg <= cmd_addr;
    end
    else if (state_reg != DBC_ST_IDLE)
    begin
      ptr_reg <= ptr_next;
    end
    else if (bus_wr && avs_address == DBC_OFS_PTR)
    begin
      ptr_reg <= avs_writedata[DBC_AW-1:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      last_reg <= DBC_CMD_SYNC;
    end
    else if (take)
    begin
      last_reg <= dbc_cmd_t'(cmd_code);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cur_reg     <= DBC_CMD_NOP;
      stat_en_reg <= 1'b0;
      size_reg    <= DBC_SIZE_BYTE;
      nbytes_reg  <= 3'h0;
    end
    else if (take)
    begin
      cur_reg     <= dbc_cmd_t'(cmd_code);
      stat_en_reg <= with_status_variant;
      size_reg    <= operand_size_field;
      nbytes_reg  <= (cmd_code == DBC_CMD_RDREG) ? DBC_REG_BYTES : cmd_bytes;
    end
  end

  // Memory port, held until acknowledged; no CPU halt is requested
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= DBC_PTR_RST;
      mem_size  <= DBC_SIZE_BYTE;
      mem_wdata <= 32'h00000000;
    end
    else if (take && legal && cmd_code >= DBC_CMD_DUMP && cmd_code <= DBC_CMD_RDMEM)
    begin
      mem_req   <= 1'b1;
      mem_we    <= (cmd_code == DBC_CMD_FILL);
      mem_addr  <= (cmd_code == DBC_CMD_RDMEM) ? cmd_addr : ptr_reg;
      mem_size  <= operand_size_field;
      mem_wdata <= cmd_data;
    end
    else if (mem_ack)
    begin
      mem_req <= 1'b0;
    end
  end

  assign cpu_reg_sel = cpu_reg_number;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      reg_masked[i*8 +: 8] = cpu_reg_impl[i] ? cpu_reg_rdata[i*8 +: 8] : 8'h00;
    end
  end

  // Captured data and status byte
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      data_reg <= 32'h00000000;
      stat_reg <= 8'h00;
    end
    else if (ill_set)
    begin
      // Low byte, so the single byte sent from the last slot is right for any size
      data_reg <= {24'h000000, DBC_ILL_RSP};
    end
    else if (take && cmd_code == DBC_CMD_RDREG)
    begin
      data_reg <= reg_masked;
      stat_reg <= debug_status_low;
    end
    else if (state_reg == DBC_ST_ACCESS && mem_ack)
    begin
      unique case (size_reg)
        DBC_SIZE_BYTE: data_reg <= {mem_rdata[7:0], 24'h000000};
        DBC_SIZE_WORD: data_reg <= {mem_rdata[15:0], 16'h0000};
        default:     data_reg <= mem_rdata;
      endcase
      stat_reg <= debug_status_low;
    end
  end

  assign returns_data = (cur_reg == DBC_CMD_DUMP) || (cur_reg == DBC_CMD_RDMEM) ||
                        (cur_reg == DBC_CMD_RDREG);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      DBC_ST_IDLE:
      begin
        if (ill_set)
        begin
          state_next = DBC_ST_DATA;
        end
        else if (take && cmd_code >= DBC_CMD_DUMP && cmd_code <= DBC_CMD_RDMEM)
        begin
          state_next = DBC_ST_ACCESS;
        end
        else if (take && cmd_code == DBC_CMD_RDREG)
        begin
          state_next = ack_en_reg ? DBC_ST_ACK :
                       with_status_variant ? DBC_ST_STAT : DBC_ST_DATA;
        end
      end
      DBC_ST_ACCESS:
      begin
        if (mem_ack)
        begin
          if (returns_data && ack_en_reg)
          begin
            state_next = DBC_ST_ACK;
          end
          else if (stat_en_reg)
          begin
            state_next = DBC_ST_STAT;
          end
          else
          begin
            state_next = returns_data ? DBC_ST_DATA : DBC_ST_IDLE;
          end
        end
      end
      DBC_ST_ACK:
      begin
        state_next = stat_en_reg ? DBC_ST_STAT : DBC_ST_DATA;
      end
      DBC_ST_STAT:
      begin
        if (push_ready)
        begin
          state_next = returns_data ? DBC_ST_DATA : DBC_ST_IDLE;
        end
      end
      DBC_ST_DATA:
      begin
        if (push_ready && sent_reg + 3'h1 >= nbytes_reg)
        begin
          state_next = DBC_ST_IDLE;
        end
      end
      default:
      begin
        state_next = DBC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_reg <= DBC_ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Illegal response is a single byte
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      sent_reg <= 3'h0;
    end
    else if (ill_set)
    begin
      sent_reg <= DBC_REG_BYTES - 3'h1;
    end
    else if (state_reg == DBC_ST_DATA && push_ready)
    begin
      sent_reg <= sent_reg + 3'h1;
    end
    else if (state_reg != DBC_ST_DATA)
    begin
      sent_reg <= 3'h0;
    end
  end

  always_comb
  begin
    push      = 1'b0;
    push_data = 8'h00;
    if (state_reg == DBC_ST_STAT)
    begin
      push      = 1'b1;
      push_data = stat_reg;
    end
    else if (state_reg == DBC_ST_DATA)
    begin
      push      = 1'b1;
      push_data = data_reg[(3 - 32'(sent_reg)) * 8 +: 8];
    end
  end

  // Receiver stall holds the engine in STAT or DATA
  dbc_buf2 #(
    .W (8)
  ) u_rsp_buf (
    .mclk      (mclk),
    .srst      (srst),
    .in_valid  (push),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (rsp_valid),
    .out_ready (rsp_ready),
    .out_data  (rsp_data)
  );

  assign ack_pulse = (state_reg == DBC_ST_ACK);
endmodule

// [dv/dbc_engine_assertions.sv]
// Concurrent checks on the debug command engine ports
`timescale 1ns/1ps
module dbc_engine_assertions
  import dbc_pkg::*;
(
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic [2:0] cmd_code,
  input wire logic       background_halt_mode,
  input wire logic       ack_pulse,
  input wire logic       mem_req,
  input wire logic       mem_we,
  input wire logic [3:0] cpu_reg_number,
  input wire logic [3:0] cpu_reg_sel
);
  logic       take;
  logic [2:0] last_reg;
  assign take = cmd_valid && cmd_ready;
  // The engine counts the first command after reset as following a sync
  always_ff @(posedge mclk)
    if (srst)
      last_reg <= DBC_CMD_SYNC;
    else if (take)
      last_reg <= cmd_code;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  property p_dump_ill;
    take && cmd_code == DBC_CMD_DUMP && (last_reg == DBC_CMD_FILL || last_reg == DBC_CMD_RDREG)
      |=> !mem_req [*3];
  endproperty
  a_dump_ill: assert property (p_dump_ill)
    else $error("illegal dump reached memory");
  property p_dump_ok;
    take && cmd_code == DBC_CMD_DUMP && (last_reg == DBC_CMD_RDMEM || last_reg == DBC_CMD_NOP)
      |=> mem_req && !mem_we;
  endproperty
  a_dump_ok: assert property (p_dump_ok)
    else $error("legal dump gave no read");
  property p_nop;
    take && cmd_code == DBC_CMD_NOP |=> (!mem_req && !ack_pulse) [*2];
  endproperty
  a_nop: assert property (p_nop)
    else $error("no-op caused activity");
  property p_fill;
    take && cmd_code == DBC_CMD_FILL |=> mem_req && mem_we;
  endproperty
  a_fill: assert property (p_fill)
    else $error("fill gave no write");
  property p_rdmem;
    take && cmd_code == DBC_CMD_RDMEM |=> mem_req && !mem_we;
  endproperty
  a_rdmem: assert property (p_rdmem)
    else $error("memory read gave no read");
  property p_ill_reg;
    take && cmd_code == DBC_CMD_RDREG && !background_halt_mode
      |=> (!ack_pulse && !mem_req) [*4];
  endproperty
  a_ill_reg: assert property (p_ill_reg)
    else $error("register read outside halt acted");
  property p_sel;
    take && cmd_code == DBC_CMD_RDREG |-> cpu_reg_sel == cpu_reg_number;
  endproperty
  a_sel: assert property (p_sel)
    else $error("register select mismatch");
  property p_ack;
    ack_pulse |=> !ack_pulse && !cmd_ready;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack pulse not followed by data");
endmodule
bind dbc_engine dbc_engine_assertions u_chk (.mclk, .srst, .cmd_valid, .cmd_ready,
  .cmd_code, .background_halt_mode, .ack_pulse, .mem_req, .mem_we, .cpu_reg_number,
  .cpu_reg_sel);

// [dv/dbc_mem_model.sv]
// Behavioural device memory behind the engine's memory port
`timescale 1ns/1ps
module dbc_mem_model
  import dbc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic [3:0]        lat,
  input  wire logic              mem_req,
  input  wire logic              mem_we,
  input  wire logic [DBC_AW-1:0] mem_addr,
  input  wire logic [1:0]        mem_size,
  input  wire logic [31:0]       mem_wdata,
  output logic                   mem_ack,
  output logic [31:0]            mem_rdata
);
  logic [7:0]  mem [256];
  logic [3:0]  cnt;
  logic [31:0] rd;
  int          n;
  initial
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'hA5;
  always @(posedge mclk)
    if (srst)
    begin
      mem_ack <= 1'b0;
      cnt     <= 4'h0;
    end
    else if (mem_ack || !mem_req)
    begin
      // Read data is only good with the ack, so it churns otherwise
      mem_ack   <= 1'b0;
      cnt       <= 4'h0;
      mem_rdata <= ~mem_rdata;
    end
    else if (cnt < lat)
      cnt <= cnt + 4'h1;
    else
    begin
      n = (mem_size == DBC_SIZE_BYTE) ? 1 : (mem_size == DBC_SIZE_WORD) ? 2 : 4;
      rd = 32'h0;
      for (int i = 0; i < n; i++)
        if (mem_we)
          mem[8'(mem_addr) + 8'(i)] <= mem_wdata[8*(n-1-i) +: 8];
        else
          rd = {rd[23:0], mem[8'(mem_addr) + 8'(i)]};
      mem_ack   <= 1'b1;
      mem_rdata <= rd;
    end
endmodule

// [dv/dbc_engine_tb_top.sv]
// Self-checking bench for the debug command engine
`timescale 1ns/1ps
module dbc_engine_tb_top
  import dbc_pkg::*;
;
  logic              mclk, srst, avs_read, avs_write, avs_waitrequest, ack_pulse;
  logic [3:0]        avs_address, avs_byteenable, cpu_reg_number, cpu_reg_sel;
  logic [31:0]       avs_writedata, avs_readdata, cmd_data, mem_wdata, mem_rdata, rd;
  logic              cmd_valid, cmd_ready, with_status_variant, rsp_valid, rsp_ready;
  logic [2:0]        cmd_code;
  logic [1:0]        operand_size_field, mem_size;
  logic [DBC_AW-1:0] cmd_addr, mem_addr;
  logic [3:0]        cpu_reg_impl, lat;
  logic [7:0]        rsp_data;
  logic              mem_req, mem_we, mem_ack, background_halt_mode;
  logic [31:0]       cpu_reg_rdata;
  logic [8:0]        got[$], exp[$];
  int                mismatches, checks;
  assign cpu_reg_rdata = {8{cpu_reg_sel}};
  always #50 mclk = ~mclk;
  dbc_engine u_dut (.mclk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .cmd_valid, .cmd_ready, .cmd_code,
    .with_status_variant, .operand_size_field, .cmd_addr, .cmd_data, .cpu_reg_number,
    .rsp_valid, .rsp_ready, .rsp_data, .ack_pulse, .mem_req, .mem_we, .mem_addr, .mem_size,
    .mem_wdata, .mem_ack, .mem_rdata, .background_halt_mode, .cpu_reg_sel, .cpu_reg_rdata,
    .cpu_reg_impl);
  dbc_mem_model u_mem (.mclk, .srst, .lat, .mem_req, .mem_we, .mem_addr, .mem_size,
    .mem_wdata, .mem_ack, .mem_rdata);
  // Ack pulses are logged as 0x100 so their place among the bytes is checked
  always @(posedge mclk)
    if (!srst)
    begin
      if (ack_pulse)
        got.push_back(9'h100);
      if (rsp_valid && rsp_ready)
        got.push_back({1'b0, rsp_data});
    end
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !w;
    avs_write     <= w;
    do
      @(posedge mclk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic cmd(input logic [2:0] c, input logic st, input logic [1:0] size,
                     input logic [23:0] a, input logic [31:0] d, input logic [3:0] rn);
    @(posedge mclk);
    cmd_valid           <= 1'b1;
    cmd_code            <= c;
    with_status_variant <= st;
    operand_size_field  <= size;
    cmd_addr            <= a;
    cmd_data            <= d;
    cpu_reg_number      <= rn;
    do
      @(posedge mclk);
    while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
  endtask
  task automatic drain();
    int t;
    t = 0;
    do
    begin
      @(negedge mclk);
      t++;
    end
    while ((got.size() < exp.size() || cmd_ready !== 1'b1 || rsp_valid !== 1'b0) && t < 200);
    chk(t < 200, 1);
    chk(got.size(), exp.size());
    foreach (exp[i])
      if (i < got.size())
        chk(got[i], exp[i]);
    got.delete();
    exp.delete();
  endtask
  function automatic logic [8:0] mb(input int a);
    return {1'b0, 8'(a) ^ 8'hA5};
  endfunction
  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    end_sim();
  end
  initial
  begin
    {mclk, avs_read, avs_write, cmd_valid, background_halt_mode} = '0;
    {avs_address, avs_writedata, cmd_code, with_status_variant} = '0;
    {operand_size_field, cmd_addr, cmd_data, cpu_reg_number, lat} = '0;
    srst = 1'b1;
    rsp_ready = 1'b1;
    avs_byteenable = 4'hF;
    cpu_reg_impl = 4'hF;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    bus(0, DBC_OFS_CTRL, 0);
    chk(rd, 32'h0);
    bus(0, 4'hC, 0);
    chk(rd, 32'h0);
    bus(1, DBC_OFS_CTRL, 32'h1);
    cmd(DBC_CMD_RDMEM, 1, DBC_SIZE_LONG, 24'h10, 0, 0);
    exp = '{9'h100, 9'h080, mb(16), mb(17), mb(18), mb(19)};
    drain();
    for (int i = 0; i < 3; i++)
    begin
      cmd(DBC_CMD_DUMP, 0, 2'(2 - i), 0, 0, 0);
      exp.push_back(9'h100);
      for (int k = 0; k < (4 >> i); k++)
        exp.push_back(mb(16 + 4 * (i > 0) + 2 * (i > 1) + k));
      drain();
      cmd(DBC_CMD_NOP, 0, 0, 0, 0, 0);
      drain();
    end
    bus(0, DBC_OFS_PTR, 0);
    chk(rd, 32'h17);
    bus(1, DBC_OFS_PTR, 32'h40);
    cmd(DBC_CMD_FILL, 0, DBC_SIZE_WORD, 0, 32'h1234, 0);
    drain();
    cmd(DBC_CMD_FILL, 1, DBC_SIZE_BYTE, 0, 32'hAB, 0);
    exp = '{9'h080};
    drain();
    bus(0, DBC_OFS_PTR, 0);
    chk(rd, 32'h43);
    cmd(DBC_CMD_DUMP, 0, DBC_SIZE_BYTE, 0, 0, 0);
    exp = '{9'h0EE};
    drain();
    bus(0, DBC_OFS_STAT, 0);
    chk(rd[7:0], 8'hA0);
    bus(1, DBC_OFS_STAT, 32'h20);
    cmd(DBC_CMD_RDMEM, 0, DBC_SIZE_LONG, 24'h40, 0, 0);
    exp = '{9'h100, 9'h012, 9'h034, 9'h0AB, mb(67)};
    drain();
    cmd(DBC_CMD_RDREG, 0, 0, 0, 0, 4'h3);
    exp = '{9'h0EE};
    drain();
    bus(1, DBC_OFS_STAT, 32'h20);
    background_halt_mode <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      cpu_reg_impl <= i ? 4'hA : 4'h5;
      cmd(DBC_CMD_RDREG, 0, 0, 0, 0, i ? 4'hA : 4'h3);
      exp.push_back(9'h100);
      for (int k = 3; k >= 0; k--)
        exp.push_back(cpu_reg_impl[k] ? {1'b0, {2{cpu_reg_number}}} : 9'h000);
      drain();
    end
    rsp_ready <= 1'b0;
    lat <= 4'h6;
    cmd(DBC_CMD_RDMEM, 1, DBC_SIZE_LONG, 24'h10, 0, 0);
    repeat (30) @(posedge mclk);
    chk(got.size(), 1);
    rsp_ready <= 1'b1;
    exp = '{9'h100, 9'h0C0, mb(16), mb(17), mb(18), mb(19)};
    drain();
    // Acknowledge off: status and data only, no pulse
    bus(1, DBC_OFS_CTRL, 32'h0);
    cmd(DBC_CMD_RDMEM, 1, DBC_SIZE_BYTE, 24'h20, 0, 0);
    exp = '{9'h040, mb(32)};
    drain();
    end_sim();
  end
endmodule
